// ==== design/rsl_pkg.sv ====
/*
  rsl_pkg: shared constants for the reference switch and lock monitor.
  assumes: a single 10 MHz system clock and flattened per-loop port vectors.
*/
package rsl_pkg;
  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NUM_IN      = 14;  // reference inputs
  localparam int NUM_LOS     = 4;   // loss-of-signal pins
  localparam int NUM_LOOP    = 3;   // loop_one, loop_two, loop_three
  localparam int NUM_ALM     = 2;   // loops with a phase lock alarm
  localparam int IDX_W       = 4;   // input index width, 0 means none
  localparam int PRIO_W      = 4;   // priority width, lower value wins
  localparam int FINE_W      = 3;   // fine phase limit field
  localparam int SOFT_W      = 7;   // soft frequency limit field
  localparam int HARD_W      = 16;  // hard frequency limit field
  localparam int TOV_W       = 6;   // lock timeout value field
  localparam int SCALE_W     = 2;   // lock timeout scale field
  localparam int PER_W       = 16;  // nominal input period in cycles
  localparam int GAP_W       = 18;  // missing-edge gap counter
  localparam int PHE_W       = 8;   // phase error magnitude
  localparam int FOFS_W      = 24;  // offset magnitude, 0.0002 ppm units
  localparam int LIM_W       = 19;  // scaled frequency limit
  localparam int AGE_W       = 8;   // seconds counter of alarms
  localparam int LCNT_W      = 26;  // lock qualification counter
  localparam int SCNT_W      = 24;  // seconds prescaler
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int SYS_CLK_HZ  = 10_000_000;
  localparam int SEC_TIME_S  = 1;   // timebase tick period
  localparam int LOCK_TIME_S = 2;   // lock qualification time
  localparam int SEC_CYCLES  = SYS_CLK_HZ * SEC_TIME_S;
  localparam int LOCK_CYCLES = SEC_CYCLES * LOCK_TIME_S;
  localparam int MISS_EDGES  = 3;   // missed input cycles for fast loss
  // ****************************************************************
  // limit scaling: offset unit is 0.0002 ppm
  // ****************************************************************
  localparam logic [11:0] SOFT_STEP = 12'hE24;  // 0.724 ppm
  localparam logic [11:0] HARD_STEP = 12'h007;  // 0.0014 ppm
  localparam logic [4:0]  FINE_STEP = 5'h1F;    // phase units per limit step
  localparam logic [IDX_W-1:0] NO_REF = 4'h0;
endpackage : rsl_pkg

// ==== design/rsl_lock_mon.sv ====
/*
  rsl_lock_mon: lock qualification of one loop.
  assumes: event inputs are levels on ref_clk; enables are static software bits.
*/
`timescale 1ns/10ps
module rsl_lock_mon #(
  parameter int LOCK_CYC = rsl_pkg::LOCK_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic ce,
  input  wire logic fast_loss,
  input  wire logic fast_en,
  input  wire logic fine_loss,
  input  wire logic fine_en,
  input  wire logic coarse_loss,
  input  wire logic coarse_en,
  input  wire logic hard_alarm,
  input  wire logic hard_en,
  input  wire logic restart,
  output logic      locked
);
  // ****************************************************************
  // qualification timer
  // ****************************************************************
  logic                      unlock_ev;
  logic [rsl_pkg::LCNT_W-1:0] quiet_r;

  // only enabled events break lock
  assign unlock_ev = (fast_loss & fast_en) | (fine_loss & fine_en)
                   | (hard_alarm & hard_en) | (coarse_loss & coarse_en);

  // count quiet cycles, lock after the full interval
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      quiet_r <= '0;
    else if (ce)
    begin
      if (unlock_ev || restart)
        quiet_r <= '0;
      else if (quiet_r < LOCK_CYC[rsl_pkg::LCNT_W-1:0])
        quiet_r <= quiet_r + 1'b1;
    end
  end

  assign locked = (quiet_r == LOCK_CYC[rsl_pkg::LCNT_W-1:0]);
endmodule : rsl_lock_mon

// ==== design/rsl_ref_switch.sv ====
/*
  rsl_ref_switch: reference selection, loss pins, loss events and lock
  supervision for three digital loops.
  assumes: reference clocks and loss pins are asynchronous pins; qualification,
  phase error and frequency offset come from logic on ref_clk.
*/
//
// Functional notes
// - loops one and two revert by a bit; loop three always reverts
// - revertive: switch on disqualification or when a better qualified input exists
// - revertive selection takes the highest priority qualified input
// - non-revertive: keep input until disqualified, then take the best one
// - selected index reported on 4 bits; takes the best index one cycle later when revertive
// - four loss pins; high pin disqualifies its associated inputs
// - per-input enables map loss pins; none mapped after reset
// - fast loss after 3 missed input cycles, cleared by next edge
// - fast loss unlocks loops one and two by bit, loop three always
// - fine phase loss while error exceeds 3-bit limit; unlocks when enabled
// - soft and hard frequency alarms; only hard unlocks, when enabled
// - soft limit is field times 0.724 ppm
// - hard limit is field times 0.0014 ppm
// - locked after 2 seconds free of enabled events; shown on status and pins
// - disabled events, coarse included, never affect lock
// - loops one and two raise per-input alarm when lock exceeds timeout
// - alarm cleared by write-one or automatically after the timeout period
// - alarmed input is disqualified for loops one and two
`timescale 1ns/10ps
module rsl_ref_switch #(
  parameter int SEC_CYC  = rsl_pkg::SEC_CYCLES,
  parameter int LOCK_CYC = rsl_pkg::LOCK_CYCLES
) (
  input  wire logic                                                  ref_clk,
  input  wire logic                                                  rstn,
  input  wire logic                                                  ce,
  input  wire logic [rsl_pkg::NUM_IN-1:0]                            ref_clk_pins,
  input  wire logic [rsl_pkg::NUM_LOS-1:0]                           signal_loss_pins,
  input  wire logic [rsl_pkg::NUM_IN*rsl_pkg::NUM_LOS-1:0]           loss_pin_assign_en,
  input  wire logic [rsl_pkg::NUM_IN-1:0]                            ref_qualified,
  input  wire logic [rsl_pkg::NUM_IN*rsl_pkg::PRIO_W-1:0]            ref_priority,
  input  wire logic [rsl_pkg::NUM_ALM-1:0]                           revertive_en,
  input  wire logic [rsl_pkg::NUM_LOOP*rsl_pkg::PER_W-1:0]           ref_period,
  input  wire logic [rsl_pkg::NUM_ALM-1:0]                           fast_loss_unlock_en,
  input  wire logic [rsl_pkg::NUM_LOOP*rsl_pkg::PHE_W-1:0]           phase_err,
  input  wire logic [rsl_pkg::NUM_LOOP*rsl_pkg::FINE_W-1:0]          fine_phase_limit,
  input  wire logic [rsl_pkg::NUM_LOOP-1:0]                          fine_phase_unlock_en,
  input  wire logic [rsl_pkg::NUM_LOOP-1:0]                          coarse_phase_loss,
  input  wire logic [rsl_pkg::NUM_LOOP-1:0]                          coarse_phase_unlock_en,
  input  wire logic [rsl_pkg::NUM_LOOP*rsl_pkg::FOFS_W-1:0]          freq_offset,
  input  wire logic [rsl_pkg::NUM_LOOP*rsl_pkg::SOFT_W-1:0]          soft_freq_limit,
  input  wire logic [rsl_pkg::NUM_LOOP*rsl_pkg::HARD_W-1:0]          hard_freq_limit,
  input  wire logic [rsl_pkg::NUM_LOOP-1:0]                          hard_freq_unlock_en,
  input  wire logic [rsl_pkg::NUM_ALM*rsl_pkg::TOV_W-1:0]            lock_timeout_value,
  input  wire logic [rsl_pkg::NUM_ALM*rsl_pkg::SCALE_W-1:0]          lock_timeout_scale,
  input  wire logic [rsl_pkg::NUM_ALM-1:0]                           alarm_autoclear_sel,
  input  wire logic [rsl_pkg::NUM_ALM*rsl_pkg::NUM_IN-1:0]           alarm_clear_w1c,
  output logic      [rsl_pkg::NUM_LOOP*rsl_pkg::IDX_W-1:0]           active_ref_index,
  output logic      [rsl_pkg::NUM_LOOP*rsl_pkg::IDX_W-1:0]           best_valid_ref_index,
  output logic      [rsl_pkg::NUM_LOOP-1:0]                          fast_loss,
  output logic      [rsl_pkg::NUM_LOOP-1:0]                          fine_phase_loss,
  output logic      [rsl_pkg::NUM_LOOP-1:0]                          soft_freq_alarm,
  output logic      [rsl_pkg::NUM_LOOP-1:0]                          hard_freq_alarm,
  output logic      [rsl_pkg::NUM_LOOP-1:0]                          loop_locked,
  output logic      [rsl_pkg::NUM_LOOP-1:0]                          lock_pins,
  output logic      [rsl_pkg::NUM_ALM*rsl_pkg::NUM_IN-1:0]           phase_lock_alarm_flag
);
  localparam int NI = rsl_pkg::NUM_IN;
  localparam int NL = rsl_pkg::NUM_LOS;
  localparam int IW = rsl_pkg::IDX_W;
  localparam int PW = rsl_pkg::PRIO_W;

  // ****************************************************************
  // best qualified input: lowest priority value wins, 0 means none
  // ****************************************************************
  function automatic logic [rsl_pkg::IDX_W-1:0] best_of(
    input logic [rsl_pkg::NUM_IN-1:0]               qual,
    input logic [rsl_pkg::NUM_IN*rsl_pkg::PRIO_W-1:0] prio
  );
    logic [rsl_pkg::IDX_W-1:0]  idx;
    logic [rsl_pkg::PRIO_W-1:0] bp;
    idx = rsl_pkg::NO_REF;
    bp  = '1;
    for (int i = 0; i < rsl_pkg::NUM_IN; i++)
    begin
      if (qual[i] && (idx == rsl_pkg::NO_REF || prio[i*rsl_pkg::PRIO_W +: rsl_pkg::PRIO_W] < bp))
      begin
        idx = rsl_pkg::IDX_W'(i + 1);
        bp  = prio[i*rsl_pkg::PRIO_W +: rsl_pkg::PRIO_W];
      end
    end
    return idx;
  endfunction : best_of

  // ****************************************************************
  // pin synchronisers: three stages, a change counts when 2 and 3 agree
  // ****************************************************************
  logic [NI+NL-1:0] pin_s1_r;
  logic [NI+NL-1:0] pin_s2_r;
  logic [NI+NL-1:0] pin_s3_r;
  logic [NI+NL-1:0] pin_f_r;
  logic [NI-1:0]    ref_edge_r;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
    end
    else if (ce)
    begin
      pin_s1_r <= {signal_loss_pins, ref_clk_pins};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // filtered level and rising edge of each reference
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      pin_f_r    <= '0;
      ref_edge_r <= '0;
    end
    else if (ce)
    begin
      pin_f_r    <= (pin_s2_r & pin_s3_r) | (pin_f_r & (pin_s2_r | pin_s3_r));
      ref_edge_r <= pin_s2_r[NI-1:0] & pin_s3_r[NI-1:0] & ~pin_f_r[NI-1:0];
    end
  end

  // ****************************************************************
  // loss pin mapping, cleared by reset
  // ****************************************************************
  logic [NI*NL-1:0] los_map_r;
  logic [NI-1:0]    los_disq;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      los_map_r <= '0;
    else if (ce)
      los_map_r <= loss_pin_assign_en;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NI; gi++)
    begin : g_los
      assign los_disq[gi] = |(los_map_r[gi*NL +: NL] & pin_f_r[NI +: NL]);
    end
  endgenerate

  // ****************************************************************
  // seconds timebase
  // ****************************************************************
  logic [rsl_pkg::SCNT_W-1:0] sec_cnt_r;
  logic                      sec_tick;

  assign sec_tick = (sec_cnt_r == rsl_pkg::SCNT_W'(SEC_CYC - 1));

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      sec_cnt_r <= '0;
    else if (ce)
      sec_cnt_r <= sec_tick ? '0 : sec_cnt_r + 1'b1;
  end

  // ****************************************************************
  // per loop: selection, loss events, lock; phase lock alarm on loops one and two only
  // ****************************************************************
  genvar gl;
  generate
    for (gl = 0; gl < rsl_pkg::NUM_LOOP; gl++)
    begin : g_loop
      logic [NI-1:0]              alarm_vec;
      logic [NI-1:0]              qual;
      logic [IW-1:0]              best;
      logic [IW-1:0]              sel_r;
      logic                       revert;
      logic                       sel_bad;
      logic [rsl_pkg::GAP_W-1:0]  gap_r;
      logic [rsl_pkg::GAP_W-1:0]  gap_lim;
      logic                       fast_r;
      logic                       fine_r;
      logic                       soft_r;
      logic                       hard_r;
      logic                       fast_en;
      logic                       locked;
      logic [rsl_pkg::FOFS_W-1:0] ofs;

      // qualification per loop, alarmed inputs removed on loops one and two
      assign qual    = ref_qualified & ~los_disq & ~alarm_vec;
      assign best    = best_of(qual, ref_priority);
      assign revert  = (gl == rsl_pkg::NUM_LOOP - 1) ? 1'b1 : revertive_en[gl % rsl_pkg::NUM_ALM];
      assign sel_bad = (sel_r == rsl_pkg::NO_REF) || !qual[sel_r - 1'b1];

      // selected input register
      always_ff @(posedge ref_clk)
      begin
        if (!rstn)
          sel_r <= rsl_pkg::NO_REF;
        else if (ce)
        begin
          if (revert)
            sel_r <= best;
          else if (sel_bad)
            sel_r <= best;
        end
      end

      assign active_ref_index[gl*IW +: IW]     = sel_r;
      assign best_valid_ref_index[gl*IW +: IW] = best;

      // fast loss: gap beyond three nominal input periods
      assign gap_lim = rsl_pkg::GAP_W'(ref_period[gl*rsl_pkg::PER_W +: rsl_pkg::PER_W])
                     * rsl_pkg::GAP_W'(rsl_pkg::MISS_EDGES);
      always_ff @(posedge ref_clk)
      begin
        if (!rstn)
        begin
          gap_r  <= '0;
          fast_r <= 1'b0;
        end
        else if (ce)
        begin
          if (sel_r == rsl_pkg::NO_REF || ref_edge_r[sel_r - 1'b1] || sel_r != best && revert)
          begin
            gap_r  <= '0;
            fast_r <= 1'b0;
          end
          else
          begin
            if (gap_r != '1)
              gap_r <= gap_r + 1'b1;
            if (gap_r >= gap_lim)
              fast_r <= 1'b1;
          end
        end
      end

      // fine phase and frequency alarms, levels that follow the limits
      assign ofs = freq_offset[gl*rsl_pkg::FOFS_W +: rsl_pkg::FOFS_W];
      always_ff @(posedge ref_clk)
      begin
        if (!rstn)
        begin
          fine_r <= 1'b0;
          soft_r <= 1'b0;
          hard_r <= 1'b0;
        end
        else if (ce)
        begin
          fine_r <= phase_err[gl*rsl_pkg::PHE_W +: rsl_pkg::PHE_W]
                    > rsl_pkg::PHE_W'(fine_phase_limit[gl*rsl_pkg::FINE_W +: rsl_pkg::FINE_W]
                    * rsl_pkg::FINE_STEP);
          soft_r <= ofs > rsl_pkg::FOFS_W'(soft_freq_limit[gl*rsl_pkg::SOFT_W +: rsl_pkg::SOFT_W]
                    * rsl_pkg::SOFT_STEP);
          hard_r <= ofs > rsl_pkg::FOFS_W'(hard_freq_limit[gl*rsl_pkg::HARD_W +: rsl_pkg::HARD_W]
                    * rsl_pkg::HARD_STEP);
        end
      end

      assign fast_loss[gl]       = fast_r;
      assign fine_phase_loss[gl] = fine_r;
      assign soft_freq_alarm[gl] = soft_r;
      assign hard_freq_alarm[gl] = hard_r;
      assign fast_en = (gl == rsl_pkg::NUM_LOOP - 1) ? 1'b1 : fast_loss_unlock_en[gl % rsl_pkg::NUM_ALM];

      // lock qualification, restarted while no input is selected
      rsl_lock_mon #(
        .LOCK_CYC (LOCK_CYC)
      ) u_lock (
        .ref_clk     (ref_clk),
        .rstn        (rstn),
        .ce          (ce),
        .fast_loss   (fast_r),
        .fast_en     (fast_en),
        .fine_loss   (fine_r),
        .fine_en     (fine_phase_unlock_en[gl]),
        .coarse_loss (coarse_phase_loss[gl]),
        .coarse_en   (coarse_phase_unlock_en[gl]),
        .hard_alarm  (hard_r),
        .hard_en     (hard_freq_unlock_en[gl]),
        .restart     (sel_r == rsl_pkg::NO_REF),
        .locked      (locked)
      );
      assign loop_locked[gl] = locked;
      assign lock_pins[gl]   = locked;

      if (gl < rsl_pkg::NUM_ALM)
      begin : g_alm
        logic [rsl_pkg::AGE_W-1:0] period;
        logic [rsl_pkg::AGE_W-1:0] wait_r;
        logic [IW-1:0]             prev_r;
        logic                      raise;
        logic [NI-1:0]             flag_r;

        assign period = rsl_pkg::AGE_W'(lock_timeout_value[gl*rsl_pkg::TOV_W +: rsl_pkg::TOV_W]
                      * lock_timeout_scale[gl*rsl_pkg::SCALE_W +: rsl_pkg::SCALE_W]);
        assign raise  = sec_tick && !locked && sel_r != rsl_pkg::NO_REF
                      && period != '0 && wait_r + 1'b1 >= period;

        // seconds spent unlocked on the current input
        always_ff @(posedge ref_clk)
        begin
          if (!rstn)
          begin
            wait_r <= '0;
            prev_r <= rsl_pkg::NO_REF;
          end
          else if (ce)
          begin
            prev_r <= sel_r;
            if (locked || sel_r != prev_r || raise)
              wait_r <= '0;
            else if (sec_tick)
              wait_r <= wait_r + 1'b1;
          end
        end

        for (gi = 0; gi < NI; gi++)
        begin : g_flag
          logic [rsl_pkg::AGE_W-1:0] age_r;
          logic                      set;
          logic                      clr;

          assign set = raise && sel_r == IW'(gi + 1);
          assign clr = alarm_autoclear_sel[gl] ? (sec_tick && age_r + 1'b1 >= period)
                                               : alarm_clear_w1c[gl*NI + gi];

          // alarm flag, a set in the clearing cycle wins
          always_ff @(posedge ref_clk)
          begin
            if (!rstn)
            begin
              flag_r[gi] <= 1'b0;
              age_r      <= '0;
            end
            else if (ce)
            begin
              if (set)
              begin
                flag_r[gi] <= 1'b1;
                age_r      <= '0;
              end
              else if (flag_r[gi] && clr)
                flag_r[gi] <= 1'b0;
              else if (flag_r[gi] && sec_tick)
                age_r <= age_r + 1'b1;
            end
          end
        end

        assign alarm_vec = flag_r;
        assign phase_lock_alarm_flag[gl*NI +: NI] = flag_r;
      end
      else
      begin : g_noalm
        assign alarm_vec = '0;
      end
    end
  endgenerate
endmodule : rsl_ref_switch

// ==== bench/rsl_ref_src.sv ====
/*
  rsl_ref_src: far-side reference clock sources and loss indicators.
  assumes: run and los_req come from the bench; clock phase is unrelated to ref_clk.
*/
`timescale 1ns/10ps
module rsl_ref_src #(
  parameter int HALF_NS = 400
) (
  input  wire logic [13:0] run,
  input  wire logic [3:0]  los_req,
  output logic      [13:0] clk_out,
  output logic      [3:0]  los_out
);
  // ****
  // sources
  // ****
  // running sources toggle, a stopped one drops low like a dead line
  initial
  begin
    clk_out = '0;
    #37;
    forever #(HALF_NS) clk_out = ~clk_out & run;
  end
  // loss indicators follow the request
  assign los_out = los_req;
endmodule : rsl_ref_src

// ==== bench/rsl_ref_switch_chk.sv ====
/*
  rsl_ref_switch_chk: port assertions for rsl_ref_switch.
  assumes: one clock domain; bound to the top module below.
*/
`timescale 1ns/10ps
module rsl_ref_switch_chk (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic [13:0] ref_qualified,
  input wire logic [3:0]  signal_loss_pins,
  input wire logic [1:0]  revertive_en,
  input wire logic [23:0] phase_err,
  input wire logic [8:0]  fine_phase_limit,
  input wire logic [71:0] freq_offset,
  input wire logic [20:0] soft_freq_limit,
  input wire logic [47:0] hard_freq_limit,
  input wire logic [2:0]  hard_freq_unlock_en,
  input wire logic [11:0] active_ref_index,
  input wire logic [11:0] best_valid_ref_index,
  input wire logic [2:0]  fast_loss,
  input wire logic [2:0]  fine_phase_loss,
  input wire logic [2:0]  soft_freq_alarm,
  input wire logic [2:0]  hard_freq_alarm,
  input wire logic [2:0]  loop_locked,
  input wire logic [2:0]  lock_pins,
  input wire logic [27:0] phase_lock_alarm_flag
);
  // ****
  // helpers
  // ****
  // loop two input still usable
  logic [3:0] sel_two;
  logic       two_ok;
  assign sel_two = active_ref_index[7:4];
  assign two_ok  = sel_two != 4'h0 && ref_qualified[sel_two - 4'h1] && !phase_lock_alarm_flag[13 + sel_two];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ****
  // assertions
  // ****
  pins_match_a:
    assert property (lock_pins == loop_locked) else $error("lock pins differ from lock status");
  three_revert_a:
    assert property (ce |=> active_ref_index[11:8] == $past(best_valid_ref_index[11:8]))
    else $error("loop three not on best input");
  nonrev_hold_a:
    assert property ((signal_loss_pins == 4'h0 && ce) [*8] ##0 (!revertive_en[1] && two_ok)
      |=> $stable(active_ref_index[7:4])) else $error("loop two left a good input");
  soft_limit_a:
    assert property (ce |=> soft_freq_alarm[0] == ($past(freq_offset[23:0]) > 3620 * $past(soft_freq_limit[6:0])))
    else $error("soft alarm wrong");
  hard_limit_a:
    assert property (ce |=> hard_freq_alarm[0] == ($past(freq_offset[23:0]) > 7 * $past(hard_freq_limit[15:0])))
    else $error("hard alarm wrong");
  fine_limit_a:
    assert property (ce |=> fine_phase_loss[0] == ($past(phase_err[7:0]) > 31 * $past(fine_phase_limit[2:0])))
    else $error("fine phase loss wrong");
  fast_unlock_a:
    assert property (ce && fast_loss[2] |=> !loop_locked[2]) else $error("loop three locked in fast loss");
  hard_unlock_a:
    assert property (ce && hard_freq_alarm[0] && hard_freq_unlock_en[0] |=> !loop_locked[0])
    else $error("loop one locked in hard alarm");
endmodule : rsl_ref_switch_chk
bind rsl_ref_switch rsl_ref_switch_chk chk_u (.ref_clk, .rstn, .ce, .ref_qualified, .signal_loss_pins,
  .revertive_en, .phase_err, .fine_phase_limit, .freq_offset, .soft_freq_limit, .hard_freq_limit,
  .hard_freq_unlock_en, .active_ref_index, .best_valid_ref_index, .fast_loss, .fine_phase_loss,
  .soft_freq_alarm, .hard_freq_alarm, .loop_locked, .lock_pins, .phase_lock_alarm_flag);

// ==== bench/rsl_ref_switch_bench.sv ====
/*
  rsl_ref_switch_bench: directed tests of selection, loss and lock.
  assumes: short second of 20 cycles and lock time of 40 cycles.
*/
`timescale 1ns/10ps
module rsl_ref_switch_bench;
  logic        ref_clk, rstn, ce;
  logic [13:0] ref_clk_pins, ref_qualified, run;
  logic [3:0]  signal_loss_pins, los_req, lock_timeout_scale;
  logic [55:0] loss_pin_assign_en, ref_priority;
  logic [1:0]  revertive_en, fast_loss_unlock_en, alarm_autoclear_sel;
  logic [47:0] ref_period, hard_freq_limit;
  logic [23:0] phase_err;
  logic [8:0]  fine_phase_limit;
  logic [2:0]  fine_phase_unlock_en, coarse_phase_loss, coarse_phase_unlock_en, hard_freq_unlock_en;
  logic [2:0]  fast_loss, fine_phase_loss, soft_freq_alarm, hard_freq_alarm, loop_locked, lock_pins;
  logic [71:0] freq_offset;
  logic [20:0] soft_freq_limit;
  logic [11:0] lock_timeout_value, active_ref_index, best_valid_ref_index;
  logic [27:0] alarm_clear_w1c, phase_lock_alarm_flag;
  int          failures, compares, n;
  rsl_ref_src src_u (.run, .los_req, .clk_out(ref_clk_pins), .los_out(signal_loss_pins));
  rsl_ref_switch #(.SEC_CYC(20), .LOCK_CYC(40)) dut_u (.ref_clk, .rstn, .ce, .ref_clk_pins,
    .signal_loss_pins, .loss_pin_assign_en, .ref_qualified, .ref_priority, .revertive_en, .ref_period,
    .fast_loss_unlock_en, .phase_err, .fine_phase_limit, .fine_phase_unlock_en, .coarse_phase_loss,
    .coarse_phase_unlock_en, .freq_offset, .soft_freq_limit, .hard_freq_limit, .hard_freq_unlock_en,
    .lock_timeout_value, .lock_timeout_scale, .alarm_autoclear_sel, .alarm_clear_w1c, .active_ref_index,
    .best_valid_ref_index, .fast_loss, .fine_phase_loss, .soft_freq_alarm, .hard_freq_alarm,
    .loop_locked, .lock_pins, .phase_lock_alarm_flag);
  // ****
  // tasks
  // ****
  task tick(input int k);
    repeat (k) @(negedge ref_clk);
  endtask : tick
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  // ****
  // clock and watchdog
  // ****
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // the tests need under 400 cycles, allow fifteen times that
  initial
  begin
    #600000;
    failures++;
    results;
  end
  // ****
  // tests
  // ****
  initial
  begin
    {rstn, loss_pin_assign_en, ref_qualified, ref_priority, revertive_en, fast_loss_unlock_en} = '0;
    {phase_err, fine_phase_unlock_en, coarse_phase_loss, coarse_phase_unlock_en, freq_offset} = '0;
    {soft_freq_limit, hard_freq_limit, hard_freq_unlock_en, lock_timeout_value} = '0;
    {lock_timeout_scale, alarm_autoclear_sel, alarm_clear_w1c, los_req, failures, compares} = '0;
    ce = 1'b1;
    run = 14'h3FFF;
    ref_period = {3{16'h0008}};
    fine_phase_limit = 9'h1FF;
    tick(6);
    rstn = 1'b1;
    chk("sel reset", 0, active_ref_index);
    // selection: loop one revertive, loop two not, loop three always
    for (n = 0; n < 14; n++) ref_priority[n*4+:4] = 4'(n);
    ref_qualified = 14'h3FFF;
    revertive_en = 2'h1;
    tick(2);
    chk("sel all", 12'h111, active_ref_index);
    ref_qualified = 14'h3FFE;
    tick(2);
    chk("sel lost", 12'h222, active_ref_index);
    ref_qualified = 14'h3FFF;
    tick(2);
    chk("sel back", 12'h121, active_ref_index);
    chk("best", 12'h111, best_valid_ref_index);
    // clock enable low freezes the selection, release lets it move
    ce = 1'b0;
    ref_qualified = 14'h3FFE;
    tick(3);
    chk("sel frozen", 12'h121, active_ref_index);
    ce = 1'b1;
    tick(2);
    chk("sel thawed", 12'h222, active_ref_index);
    ref_qualified = 14'h3FFF;
    $display("test select done");
    // loss pins: unmapped pin is ignored, mapped pin disqualifies
    los_req = 4'h1;
    tick(8);
    chk("pin unmapped", 12'h121, active_ref_index);
    loss_pin_assign_en[0] = 1'b1;
    tick(8);
    chk("pin mapped", 12'h222, active_ref_index);
    los_req = 4'h0;
    tick(8);
    chk("pin gone", 12'h121, active_ref_index);
    $display("test loss pins done");
    // limits at their boundaries, then lock with disabled events present
    soft_freq_limit = 21'h1;
    hard_freq_limit = 48'h205;
    coarse_phase_loss = 3'h7;
    for (n = 0; n < 2; n++)
    begin
      freq_offset = 72'(3620 + n);
      phase_err = 24'(217 + n);
      tick(2);
      chk("soft", 32'(n), soft_freq_alarm[0]);
      chk("hard", 1, hard_freq_alarm[0]);
      chk("fine", 32'(n), fine_phase_loss[0]);
    end
    tick(45);
    chk("locked", 3'h7, loop_locked);
    chk("pins", 3'h7, lock_pins);
    hard_freq_unlock_en = 3'h1;
    tick(2);
    chk("hard unlock", 3'h6, loop_locked);
    hard_freq_unlock_en = 3'h0;
    tick(38);
    chk("early lock", 0, loop_locked[0]);
    tick(4);
    chk("relock", 1, loop_locked[0]);
    $display("test lock done");
    // fast loss: input one stops while still qualified
    fast_loss_unlock_en = 2'h1;
    run[0] = 1'b0;
    tick(12);
    chk("no loss yet", 0, fast_loss);
    for (n = 0; n < 40 && fast_loss[0] !== 1'b1; n++) tick(1);
    chk("fast loss", 3'h5, fast_loss);
    tick(2);
    chk("fast unlock", 3'h2, loop_locked);
    run[0] = 1'b1;
    tick(16);
    chk("loss clear", 0, fast_loss);
    $display("test fast loss done");
    // phase lock alarm: one second timeout, manual then auto clear
    hard_freq_unlock_en = 3'h1;
    lock_timeout_value = 12'h001;
    lock_timeout_scale = 4'h1;
    for (n = 0; n < 80 && phase_lock_alarm_flag[0] !== 1'b1; n++) tick(1);
    chk("alarm set", 1, phase_lock_alarm_flag[0]);
    tick(2);
    chk("alarm reselect", 2, active_ref_index[3:0]);
    alarm_clear_w1c[0] = 1'b1;
    tick(1);
    alarm_clear_w1c[0] = 1'b0;
    chk("manual clear", 0, phase_lock_alarm_flag[0]);
    alarm_autoclear_sel = 2'h1;
    for (n = 0; n < 80 && phase_lock_alarm_flag[0] !== 1'b1; n++) tick(1);
    chk("alarm again", 1, phase_lock_alarm_flag[0]);
    for (n = 0; n < 30 && phase_lock_alarm_flag[0] !== 1'b0; n++) tick(1);
    chk("auto clear", 0, phase_lock_alarm_flag[0]);
    $display("test alarm done");
    results;
  end
endmodule : rsl_ref_switch_bench
